// file: hdl/rac_regs.vh
// Register offsets, field positions, reset values and timing counts of the
// calendar, alarm and countdown block. Definitions only; included by bare name.
`ifndef RAC_REGS_VH
`define RAC_REGS_VH

`define RAC_ADDR_MONTH      5'h09
`define RAC_ADDR_YEAR       5'h0A
`define RAC_ADDR_SEC_MATCH  5'h0B
`define RAC_ADDR_MIN_MATCH  5'h0C
`define RAC_ADDR_HOUR_MATCH 5'h0D
`define RAC_ADDR_DAY_MATCH  5'h0E
`define RAC_ADDR_WDAY_MATCH 5'h0F
`define RAC_ADDR_CD_VALUE   5'h10
`define RAC_ADDR_CD_CTRL    5'h11

`define RAC_RST_MONTH       5'h01
`define RAC_RST_YEAR        8'h00
`define RAC_RST_MATCH       8'h80
`define RAC_RST_CD_VALUE    8'h00
`define RAC_RST_CD_CTRL     5'h18

`define RAC_MATCH_DIS_BIT   7
`define RAC_CTL_SRC_HI      4
`define RAC_CTL_SRC_LO      3
`define RAC_CTL_EN_BIT      2
`define RAC_CTL_IE_BIT      1
`define RAC_CTL_PULSE_BIT   0

`define RAC_SRC_4096        2'h0
`define RAC_SRC_64          2'h1
`define RAC_SRC_1HZ         2'h2
`define RAC_SRC_60S         2'h3

`define RAC_OSC_HZ          32768
`define RAC_SRC_4096_HZ     4096
`define RAC_SRC_64_HZ       64
`define RAC_SEC_PER_MIN     60

// Interrupt pulse widths, counted in 32.768 kHz oscillator cycles
`define RAC_PW_4096_N1_CYC  10'h004
`define RAC_PW_4096_CYC     10'h008
`define RAC_PW_64_N1_CYC    10'h100
`define RAC_PW_SLOW_CYC     10'h200

`endif

// file: hdl/rac_prescale.v
// Oscillator divider: source ticks for the 1 Hz time base and the countdown.
// Assumes the oscillator pin is asynchronous to i_clk and much slower than it.
`include "rac_regs.vh"
module rac_prescale #(
    parameter OSC_HZ = `RAC_OSC_HZ
) (
    input  wire       i_clk,
    input  wire       i_rst_n,
    input  wire       i_osc,
    output reg        o_osc_edge,
    output reg        o_tick_4096,
    output reg        o_tick_64,
    output reg        o_tick_1hz,
    output reg        o_tick_60s
);
    localparam D4096 = OSC_HZ / `RAC_SRC_4096_HZ;
    localparam D64   = OSC_HZ / `RAC_SRC_64_HZ;

    reg        osc_meta_q;
    reg        osc_sync_q;
    reg        osc_prev_q;
    reg [14:0] div_q;
    reg [5:0]  min_q;
    wire       edge_w = osc_sync_q & ~osc_prev_q;
    wire       wrap_w = (div_q == OSC_HZ - 1);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_meta_q  <= 1'b0;
            osc_sync_q  <= 1'b0;
            osc_prev_q  <= 1'b0;
            div_q       <= 15'h0000;
            min_q       <= 6'h00;
            o_osc_edge  <= 1'b0;
            o_tick_4096 <= 1'b0;
            o_tick_64   <= 1'b0;
            o_tick_1hz  <= 1'b0;
            o_tick_60s  <= 1'b0;
        end else begin
            osc_meta_q  <= i_osc;
            osc_sync_q  <= osc_meta_q;
            osc_prev_q  <= osc_sync_q;
            o_osc_edge  <= edge_w;
            o_tick_4096 <= edge_w & ((div_q % D4096) == D4096 - 1);
            o_tick_64   <= edge_w & ((div_q % D64) == D64 - 1);
            o_tick_1hz  <= edge_w & wrap_w;
            o_tick_60s  <= edge_w & wrap_w & (min_q == `RAC_SEC_PER_MIN - 1);
            if (edge_w) begin
                div_q <= wrap_w ? 15'h0000 : div_q + 15'h0001;
                if (wrap_w)
                    min_q <= (min_q == `RAC_SEC_PER_MIN - 1) ? 6'h00 : min_q + 6'h01;
            end
        end
    end
endmodule

// file: hdl/rac_alarm_cmp.v
// Alarm comparator: per-field match with a disable bit in bit 7 of each field.
// Current time comes from the seconds-to-weekday counters on the same clock.
`include "rac_regs.vh"
module rac_alarm_cmp (
    input  wire [7:0] i_sec_match,
    input  wire [7:0] i_min_match,
    input  wire [7:0] i_hour_match,
    input  wire [7:0] i_day_match,
    input  wire [7:0] i_wday_match,
    input  wire [7:0] i_cur_sec,
    input  wire [7:0] i_cur_min,
    input  wire [7:0] i_cur_hour,
    input  wire [7:0] i_cur_day,
    input  wire [7:0] i_cur_wday,
    output wire       o_match
);
    function hit;
        input [7:0] a;
        input [7:0] b;
        input [7:0] mask;
        begin
            hit = a[`RAC_MATCH_DIS_BIT] | ((a & mask) == (b & mask));
        end
    endfunction

    // Bit 6 of hour and day is unused; hour bit 5 is PM flag or tens bit
    wire all_hit = hit(i_sec_match,  i_cur_sec,  8'h7F) &   // [RL7]
                   hit(i_min_match,  i_cur_min,  8'h7F) &
                   hit(i_hour_match, i_cur_hour, 8'h3F) &   // [RL8]
                   hit(i_day_match,  i_cur_day,  8'h3F) &   // [RL9]
                   hit(i_wday_match, i_cur_wday, 8'h07);
    // Nothing enabled means no alarm at all, not a permanent match
    wire any_en  = ~(i_sec_match[7] & i_min_match[7] & i_hour_match[7] &
                     i_day_match[7] & i_wday_match[7]);      // [RL6]
    assign o_match = all_hit & any_en;                       // [RL10]
endmodule

// file: hdl/rac_top.v
// Month/year counting, alarm and countdown timer of a real-time clock.
// Registers arrive from the serial-bus slave on i_clk; oscillator pin is async.
// Summary of operation
// RL1: Month in BCD, tens bit 4, default January
// RL2: Year in BCD, two digits, default zero
// RL3: Time counters frozen during bus access
// RL4: One pending second stored; host finishes within one second
// RL5: Host reads time in one burst from 04h
// RL6: Bit 7 of alarm fields disables match
// RL7: Second and minute alarm fields in BCD
// RL8: Hour alarm bit 6 unused, format per select
// RL9: Day alarm tens 0-3, weekday bits 2-0
// RL10: Alarm flag set when enabled fields first match
// RL11: Interrupt follows alarm flag when enabled
// RL12: Alarm flag held until bus clear
// RL13: Eight-bit reload, period n over source frequency
// RL14: Source select bits 4-3, default one-sixtieth Hz
// RL15: Control bits enable, interrupt enable, pulse mode
// RL16: Value zero stops timer, 1-255 valid
// RL17: At count 1 set flag and reload
// RL18: Value read returns live counter
// RL19: Written reload value takes effect immediately
// RL20: Host disables timer before changing reload
// RL21: First period may run one source cycle short
// RL22: Host selects slowest source when timer unused
// RL23: Countdown flag cleared only by software
// RL24: Pulse width depends on source and n
// RL25: Interrupt is OR of enabled sources
`include "rac_regs.vh"
module rac_top #(
    parameter OSC_HZ = `RAC_OSC_HZ
) (
    input  wire       i_clk,
    input  wire       i_arst_n,
    input  wire       i_osc_32k,
    input  wire       i_acc_busy,
    input  wire       i_reg_wr,
    input  wire [4:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    input  wire       i_day_carry,
    input  wire [7:0] i_cur_sec,
    input  wire [7:0] i_cur_min,
    input  wire [7:0] i_cur_hour,
    input  wire [7:0] i_cur_day,
    input  wire [7:0] i_cur_wday,
    input  wire       i_alarm_irq_enable,
    input  wire       i_alarm_flag_clr,
    input  wire       i_countdown_flag_clr,
    output reg        o_time_tick,
    output wire [7:0] o_month,
    output wire [7:0] o_year,
    output wire       o_alarm_flag,
    output wire       o_countdown_flag,
    output wire       o_int_out,
    output reg        o_int_oe
);
    reg        rst_meta_q;
    reg        rst_q;
    wire       rst_n = rst_q;

    reg  [4:0] month_q;
    reg  [7:0] year_q;
    reg  [7:0] sec_match_q;
    reg  [7:0] min_match_q;
    reg  [7:0] hour_match_q;
    reg  [7:0] day_match_q;
    reg  [7:0] wday_match_q;
    reg  [7:0] cd_reload_q;
    reg  [7:0] cd_count_q;
    reg  [4:0] cd_ctrl_q;
    reg        pend_q;
    reg        alarm_flag_q;
    reg        match_prev_q;
    reg        cd_flag_q;
    reg  [9:0] pulse_q;
    reg  [9:0] pulse_d;

    wire       osc_edge;
    wire       tick_4096;
    wire       tick_64;
    wire       tick_1hz;
    wire       tick_60s;
    wire       alarm_match;
    reg        src_tick;

    wire [1:0] src_sel   = cd_ctrl_q[`RAC_CTL_SRC_HI:`RAC_CTL_SRC_LO];
    wire       cd_en     = cd_ctrl_q[`RAC_CTL_EN_BIT];
    wire       cd_ie     = cd_ctrl_q[`RAC_CTL_IE_BIT];
    wire       cd_pulsed = cd_ctrl_q[`RAC_CTL_PULSE_BIT];

    function wr_hit;
        input [4:0] addr;
        begin
            wr_hit = i_reg_wr & (i_reg_addr == addr);
        end
    endfunction

    // Asynchronous assert, synchronous release of the reset
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    rac_prescale #(
        .OSC_HZ      (OSC_HZ)
    ) u_prescale (
        .i_clk       (i_clk),
        .i_rst_n     (rst_n),
        .i_osc       (i_osc_32k),
        .o_osc_edge  (osc_edge),
        .o_tick_4096 (tick_4096),
        .o_tick_64   (tick_64),
        .o_tick_1hz  (tick_1hz),
        .o_tick_60s  (tick_60s)
    );

    rac_alarm_cmp u_alarm_cmp (
        .i_sec_match  (sec_match_q),
        .i_min_match  (min_match_q),
        .i_hour_match (hour_match_q),
        .i_day_match  (day_match_q),
        .i_wday_match (wday_match_q),
        .i_cur_sec    (i_cur_sec),
        .i_cur_min    (i_cur_min),
        .i_cur_hour   (i_cur_hour),
        .i_cur_day    (i_cur_day),
        .i_cur_wday   (i_cur_wday),
        .o_match      (alarm_match)
    );

    // A second that lands during an access waits; a second one is lost,
    // which is why the host must keep each access under one second
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q      <= 1'b0;
            o_time_tick <= 1'b0;
        end else begin
            o_time_tick <= 1'b0;
            if (i_acc_busy) begin
                if (tick_1hz)
                    pend_q <= 1'b1;                            // [RL4]
            end else if (tick_1hz | pend_q) begin
                o_time_tick <= 1'b1;                           // [RL3]
                pend_q      <= 1'b0;
            end
        end
    end

    // Month and year counting, BCD, carried in from the day counter
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            month_q <= `RAC_RST_MONTH;
            year_q  <= `RAC_RST_YEAR;
        end else if (wr_hit(`RAC_ADDR_MONTH)) begin
            month_q <= i_reg_wdata[4:0];
        end else if (wr_hit(`RAC_ADDR_YEAR)) begin
            year_q  <= i_reg_wdata;
        end else if (i_day_carry & ~i_acc_busy) begin         // [RL3]
            if (month_q == 5'h12) begin
                month_q <= 5'h01;                              // [RL1]
                if (year_q[3:0] != 4'h9)
                    year_q[3:0] <= year_q[3:0] + 4'h1;         // [RL2]
                else begin
                    year_q[3:0] <= 4'h0;
                    year_q[7:4] <= (year_q[7:4] == 4'h9) ? 4'h0 : year_q[7:4] + 4'h1;
                end
            end else if (month_q[3:0] == 4'h9) begin
                month_q <= 5'h10;
            end else begin
                month_q <= month_q + 5'h01;
            end
        end
    end

    // Alarm field registers
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_match_q  <= `RAC_RST_MATCH;                    // [RL6]
            min_match_q  <= `RAC_RST_MATCH;
            hour_match_q <= `RAC_RST_MATCH;
            day_match_q  <= `RAC_RST_MATCH;
            wday_match_q <= `RAC_RST_MATCH;
        end else begin
            if (wr_hit(`RAC_ADDR_SEC_MATCH))
                sec_match_q  <= i_reg_wdata;                   // [RL7]
            if (wr_hit(`RAC_ADDR_MIN_MATCH))
                min_match_q  <= i_reg_wdata;
            if (wr_hit(`RAC_ADDR_HOUR_MATCH))
                hour_match_q <= {i_reg_wdata[7], 1'b0, i_reg_wdata[5:0]}; // [RL8]
            if (wr_hit(`RAC_ADDR_DAY_MATCH))
                day_match_q  <= {i_reg_wdata[7], 1'b0, i_reg_wdata[5:0]}; // [RL9]
            if (wr_hit(`RAC_ADDR_WDAY_MATCH))
                wday_match_q <= {i_reg_wdata[7], 4'h0, i_reg_wdata[2:0]};
        end
    end

    // Alarm flag: set on the rising edge of the match, held until cleared;
    // a set in the same cycle as the clear wins
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_flag_q <= 1'b0;
            match_prev_q <= 1'b0;
        end else begin
            match_prev_q <= alarm_match;
            if (alarm_match & ~match_prev_q)
                alarm_flag_q <= 1'b1;                          // [RL10]
            else if (i_alarm_flag_clr)
                alarm_flag_q <= 1'b0;                          // [RL12]
        end
    end

    // Countdown source select
    always @* begin
        case (src_sel)                                         // [RL14]
            `RAC_SRC_4096: src_tick = tick_4096;
            `RAC_SRC_64:   src_tick = tick_64;
            `RAC_SRC_1HZ:  src_tick = tick_1hz;
            `RAC_SRC_60S:  src_tick = tick_60s;
            default:       src_tick = 1'b0;
        endcase
    end

    // The enable is sampled only at source ticks, so the first period
    // may fall up to one source cycle short of n
    wire cd_expire = src_tick & cd_en & (cd_count_q == 8'h01); // [RL21]

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cd_reload_q <= `RAC_RST_CD_VALUE;                  // [RL13]
            cd_count_q  <= `RAC_RST_CD_VALUE;
            cd_ctrl_q   <= `RAC_RST_CD_CTRL;                   // [RL15]
        end else begin
            if (wr_hit(`RAC_ADDR_CD_CTRL))
                cd_ctrl_q <= i_reg_wdata[4:0];
            if (wr_hit(`RAC_ADDR_CD_VALUE)) begin
                cd_reload_q <= i_reg_wdata;
                cd_count_q  <= i_reg_wdata;                    // [RL19]
            end else if (cd_expire) begin
                cd_count_q  <= cd_reload_q;                    // [RL17]
            end else if (src_tick & cd_en & (cd_count_q != 8'h00)) begin
                cd_count_q  <= cd_count_q - 8'h01;             // [RL16]
            end
        end
    end

    // Pulse width in oscillator cycles for pulsed interrupt mode
    always @* begin
        pulse_d = pulse_q;
        if (cd_expire) begin
            case (src_sel)                                     // [RL24]
                `RAC_SRC_4096: pulse_d = (cd_reload_q == 8'h01) ?
                                         `RAC_PW_4096_N1_CYC : `RAC_PW_4096_CYC;
                `RAC_SRC_64:   pulse_d = (cd_reload_q == 8'h01) ?
                                         `RAC_PW_64_N1_CYC : `RAC_PW_SLOW_CYC;
                default:       pulse_d = `RAC_PW_SLOW_CYC;
            endcase
        end else if (osc_edge & (pulse_q != 10'h000)) begin
            pulse_d = pulse_q - 10'h001;
        end
    end

    // Countdown flag is never cleared by the timer itself
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cd_flag_q <= 1'b0;
            pulse_q   <= 10'h000;
        end else begin
            pulse_q <= pulse_d;
            if (cd_expire)
                cd_flag_q <= 1'b1;                             // [RL17]
            else if (i_countdown_flag_clr)
                cd_flag_q <= 1'b0;                             // [RL23]
        end
    end

    // Open-drain interrupt: the enable pulls the line low
    wire cd_irq    = cd_ie & (cd_pulsed ? (pulse_q != 10'h000) : cd_flag_q); // [RL15]
    wire alarm_irq = i_alarm_irq_enable & alarm_flag_q;        // [RL11]

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n)
            o_int_oe <= 1'b0;
        else
            o_int_oe <= alarm_irq | cd_irq;                    // [RL25]
    end

    // Read data registered one cycle after the address
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 8'h00;
        end else begin
            case (i_reg_addr)
                `RAC_ADDR_MONTH:      o_reg_rdata <= {3'h0, month_q};
                `RAC_ADDR_YEAR:       o_reg_rdata <= year_q;
                `RAC_ADDR_SEC_MATCH:  o_reg_rdata <= sec_match_q;
                `RAC_ADDR_MIN_MATCH:  o_reg_rdata <= min_match_q;
                `RAC_ADDR_HOUR_MATCH: o_reg_rdata <= hour_match_q;
                `RAC_ADDR_DAY_MATCH:  o_reg_rdata <= day_match_q;
                `RAC_ADDR_WDAY_MATCH: o_reg_rdata <= wday_match_q;
                `RAC_ADDR_CD_VALUE:   o_reg_rdata <= cd_count_q;   // [RL18]
                `RAC_ADDR_CD_CTRL:    o_reg_rdata <= {3'h0, cd_ctrl_q};
                default:              o_reg_rdata <= 8'h00;
            endcase
        end
    end

    assign o_month          = {3'h0, month_q};
    assign o_year           = year_q;
    assign o_alarm_flag     = alarm_flag_q;
    assign o_countdown_flag = cd_flag_q;
    assign o_int_out        = 1'b0;
endmodule

// file: test/rac_top_assertions.sv
// Checker for rac_top: blocked time, sticky flags, interrupt and read-back.
// Assumes one i_clk domain; bound to every rac_top instance.
`include "rac_regs.vh"
module rac_top_assertions (
    input wire       i_clk,
    input wire       i_arst_n,
    input wire       i_acc_busy,
    input wire       i_day_carry,
    input wire       i_reg_wr,
    input wire [4:0] i_reg_addr,
    input wire       i_alarm_irq_enable,
    input wire       i_alarm_flag_clr,
    input wire       i_countdown_flag_clr,
    input wire [7:0] o_reg_rdata,
    input wire       o_time_tick,
    input wire [7:0] o_month,
    input wire [7:0] o_year,
    input wire       o_alarm_flag,
    input wire       o_countdown_flag,
    input wire       o_int_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_alarm_held: assert property (
        o_alarm_flag && !i_alarm_flag_clr |=> o_alarm_flag)
        else $error("alarm flag dropped without clear");
    a_cd_held: assert property (
        o_countdown_flag && !i_countdown_flag_clr |=> o_countdown_flag)
        else $error("countdown flag dropped without clear");
    a_tick_blocked: assert property (i_acc_busy |=> !o_time_tick)
        else $error("second applied during bus access");
    a_time_frozen: assert property (
        i_acc_busy && !i_reg_wr |=> $stable(o_month) && $stable(o_year))
        else $error("month or year moved during bus access");
    a_alarm_int: assert property (
        i_alarm_irq_enable && o_alarm_flag |=> o_int_oe)
        else $error("interrupt missing for enabled alarm");
    a_tick_single: assert property (o_time_tick |=> !o_time_tick)
        else $error("time tick longer than one cycle");
    a_month_carry: assert property (
        i_day_carry && !i_acc_busy && !i_reg_wr && o_month == 8'h09 |=> o_month == 8'h10)
        else $error("month carry wrong");
    a_year_read: assert property (
        $past(i_reg_addr) == `RAC_ADDR_YEAR |-> o_reg_rdata == $past(o_year))
        else $error("year read-back differs");
    a_unmapped_zero: assert property (
        $past(i_reg_addr) < `RAC_ADDR_MONTH || $past(i_reg_addr) > `RAC_ADDR_CD_CTRL
        |-> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    c_alarm: cover property ($rose(o_alarm_flag));
    c_cd: cover property ($rose(o_countdown_flag));
    c_tick_late: cover property ($fell(i_acc_busy) ##[1:3] o_time_tick);
endmodule

bind rac_top rac_top_assertions u_rac_top_assertions (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_acc_busy(i_acc_busy), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_alarm_irq_enable(i_alarm_irq_enable),
    .i_alarm_flag_clr(i_alarm_flag_clr), .i_countdown_flag_clr(i_countdown_flag_clr),
    .o_reg_rdata(o_reg_rdata), .o_time_tick(o_time_tick), .o_month(o_month),
    .o_year(o_year), .o_alarm_flag(o_alarm_flag), .o_countdown_flag(o_countdown_flag),
    .o_int_oe(o_int_oe), .i_day_carry(i_day_carry));

// file: test/rac_host_model.sv
// Host-side model: free-running crystal and the serial-bus access window.
// Assumes callers keep every access shorter than one second of time base.
module rac_host_model (
    input  wire  i_clk,
    output logic o_osc_32k,
    output logic o_acc_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    // Crystal runs free; 240 ns period stays slow enough for the 2-FF sync
    initial begin
        o_osc_32k = 1'b0;
        #7;
        forever #120 o_osc_32k = ~o_osc_32k;
    end
    initial o_acc_busy = 1'b0;
    // Window opens and closes just after an edge; kept under one second
    task automatic access(input logic on);
        @(posedge i_clk);
        #2 o_acc_busy = on;
    endtask
endmodule

// file: test/rac_top_tb.sv
// Bench for rac_top: registers, alarm, countdown and the blocked time tick.
// Assumes rac_host_model supplies the crystal and the bus-access window.
`include "rac_regs.vh"
module rac_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       i_clk, i_arst_n, i_reg_wr, i_day_carry;
    logic       i_alarm_irq_enable, i_alarm_flag_clr, i_countdown_flag_clr;
    logic [4:0] i_reg_addr;
    logic [7:0] i_reg_wdata, i_cur_sec, i_cur_min, i_cur_hour, i_cur_day, i_cur_wday, v1, v2;
    wire        osc, busy, o_time_tick, o_alarm_flag, o_countdown_flag, o_int_out, o_int_oe;
    wire  [7:0] o_reg_rdata, o_month, o_year;
    int         n_fail, samples_checked, k, n;

    rac_host_model u_rac_host_model (.i_clk(i_clk), .o_osc_32k(osc), .o_acc_busy(busy));
    // Shortened time base: one second is 4096 crystal edges
    rac_top #(.OSC_HZ(4096)) u_rac_top (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_osc_32k(osc), .i_acc_busy(busy),
        .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_day_carry(i_day_carry), .i_cur_sec(i_cur_sec),
        .i_cur_min(i_cur_min), .i_cur_hour(i_cur_hour), .i_cur_day(i_cur_day),
        .i_cur_wday(i_cur_wday), .i_alarm_irq_enable(i_alarm_irq_enable),
        .i_alarm_flag_clr(i_alarm_flag_clr), .i_countdown_flag_clr(i_countdown_flag_clr),
        .o_time_tick(o_time_tick), .o_month(o_month), .o_year(o_year),
        .o_alarm_flag(o_alarm_flag), .o_countdown_flag(o_countdown_flag),
        .o_int_out(o_int_out), .o_int_oe(o_int_oe));

    initial i_clk = 1'b0;
    always #20 i_clk = ~i_clk;

    task automatic cyc();
        @(posedge i_clk);
        #2;
    endtask
    task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            $display("[ERR] %s exp %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        cyc();
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        cyc();
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        cyc();
        i_reg_addr = a;
        cyc();
        d = o_reg_rdata;
    endtask
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check("rdata", d, e);
    endtask
    task automatic cd_clear();
        i_countdown_flag_clr = 1'b1;
        cyc();
        i_countdown_flag_clr = 1'b0;
        repeat (2) cyc();
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic t_reset();
        rc(`RAC_ADDR_MONTH, 8'h01);
        rc(`RAC_ADDR_YEAR, 8'h00);
        for (int a = 11; a < 16; a++) rc(5'(a), 8'h80);
        rc(`RAC_ADDR_CD_VALUE, 8'h00);
        rc(`RAC_ADDR_CD_CTRL, 8'h18);
        rc(5'h03, 8'h00);
        rc(5'h1F, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_regs();
        wr(`RAC_ADDR_YEAR, 8'h99);
        rc(`RAC_ADDR_YEAR, 8'h99);
        wr(`RAC_ADDR_MONTH, 8'hFF);
        rc(`RAC_ADDR_MONTH, 8'h1F);
        wr(`RAC_ADDR_HOUR_MATCH, 8'hFF);
        rc(`RAC_ADDR_HOUR_MATCH, 8'hBF);
        wr(`RAC_ADDR_DAY_MATCH, 8'hFF);
        rc(`RAC_ADDR_DAY_MATCH, 8'hBF);
        wr(`RAC_ADDR_WDAY_MATCH, 8'hFF);
        rc(`RAC_ADDR_WDAY_MATCH, 8'h87);
        wr(`RAC_ADDR_SEC_MATCH, 8'h59);
        rc(`RAC_ADDR_SEC_MATCH, 8'h59);
        wr(5'h03, 8'hAA);
        rc(5'h03, 8'h00);
        for (int a = 11; a < 16; a++) wr(5'(a), 8'h80);
        $display("t_regs done");
    endtask
    task automatic t_alarm();
        i_alarm_irq_enable = 1'b1;
        i_cur_sec = 8'h25;
        repeat (3) cyc();
        check("alarm", 8'(o_alarm_flag), 8'h00);
        wr(`RAC_ADDR_SEC_MATCH, 8'h25);
        repeat (2) cyc();
        check("alarm", 8'(o_alarm_flag), 8'h01);
        check("int", 8'(o_int_oe), 8'h01);
        check("intout", 8'(o_int_out), 8'h00);
        wr(`RAC_ADDR_MIN_MATCH, 8'h30);
        i_alarm_flag_clr = 1'b1;
        cyc();
        i_alarm_flag_clr = 1'b0;
        repeat (2) cyc();
        check("alarm", 8'(o_alarm_flag), 8'h00);
        i_cur_min = 8'h30;
        repeat (2) cyc();
        check("alarm", 8'(o_alarm_flag), 8'h01);
        i_alarm_irq_enable = 1'b0;
        repeat (2) cyc();
        check("int", 8'(o_int_oe), 8'h00);
        i_alarm_flag_clr = 1'b1;
        cyc();
        i_alarm_flag_clr = 1'b0;
        repeat (4) cyc();
        check("alarm", 8'(o_alarm_flag), 8'h00);
        for (int a = 11; a < 16; a++) wr(5'(a), 8'h80);
        $display("t_alarm done");
    endtask
    task automatic t_cd();
        wr(`RAC_ADDR_CD_VALUE, 8'h03);
        wr(`RAC_ADDR_CD_CTRL, 8'h06);
        for (k = 0; k < 300 && o_countdown_flag !== 1'b1; k++) cyc();
        check("cdflag", 8'(o_countdown_flag), 8'h01);
        repeat (2) cyc();
        check("int", 8'(o_int_oe), 8'h01);
        repeat (100) cyc();
        check("cdflag", 8'(o_countdown_flag), 8'h01);
        rd(`RAC_ADDR_CD_VALUE, v1);
        check("reload", 8'(v1 >= 8'h01 && v1 <= 8'h03), 8'h01);
        // Stop before touching the reload: writes race the source tick
        wr(`RAC_ADDR_CD_CTRL, 8'h02);
        cd_clear();
        check("cdflag", 8'(o_countdown_flag), 8'h00);
        check("int", 8'(o_int_oe), 8'h00);
        wr(`RAC_ADDR_CD_VALUE, 8'hC8);
        wr(`RAC_ADDR_CD_CTRL, 8'h04);
        repeat (120) cyc();
        rd(`RAC_ADDR_CD_VALUE, v1);
        repeat (60) cyc();
        rd(`RAC_ADDR_CD_VALUE, v2);
        check("live", 8'(v1 < 8'hC8 && v2 < v1), 8'h01);
        wr(`RAC_ADDR_CD_VALUE, 8'h05);
        for (k = 0; k < 60 && o_countdown_flag !== 1'b1; k++) cyc();
        check("cdflag", 8'(o_countdown_flag), 8'h01);
        wr(`RAC_ADDR_CD_VALUE, 8'h00);
        cd_clear();
        repeat (200) cyc();
        check("cdflag", 8'(o_countdown_flag), 8'h00);
        rc(`RAC_ADDR_CD_VALUE, 8'h00);
        wr(`RAC_ADDR_CD_VALUE, 8'h14);
        wr(`RAC_ADDR_CD_CTRL, 8'h07);
        for (k = 0; k < 300 && o_int_oe !== 1'b1; k++) cyc();
        for (n = 0; n < 100 && o_int_oe === 1'b1; n++) cyc();
        check("pulse", 8'(n >= 44 && n <= 52), 8'h01);
        wr(`RAC_ADDR_CD_CTRL, 8'h18);
        cd_clear();
        $display("t_cd done");
    endtask
    task automatic t_tick();
        wr(`RAC_ADDR_MONTH, 8'h09);
        for (k = 0; k < 30000 && o_time_tick !== 1'b1; k++) cyc();
        check("tick", 8'(o_time_tick), 8'h01);
        repeat (20000) cyc();
        u_rac_host_model.access(1'b1);
        i_day_carry = 1'b1;
        cyc();
        i_day_carry = 1'b0;
        cyc();
        check("month", o_month, 8'h09);
        n = 0;
        repeat (8000) begin
            cyc();
            n += (o_time_tick === 1'b1);
        end
        check("tickbusy", 8'(n), 8'h00);
        u_rac_host_model.access(1'b0);
        for (k = 0; k < 3 && o_time_tick !== 1'b1; k++) cyc();
        check("tick", 8'(o_time_tick), 8'h01);
        i_day_carry = 1'b1;
        cyc();
        i_day_carry = 1'b0;
        cyc();
        check("month", o_month, 8'h10);
        $display("t_tick done");
    endtask

    initial begin
        i_arst_n = 1'b0;
        {i_reg_wr, i_day_carry, i_alarm_irq_enable, i_alarm_flag_clr, i_countdown_flag_clr} = '0;
        {i_reg_addr, i_reg_wdata, i_cur_sec, i_cur_min, i_cur_hour, i_cur_day, i_cur_wday} = '0;
        repeat (16) @(posedge i_clk);
        #2 i_arst_n = 1'b1;
        repeat (3) cyc();
        t_reset();
        t_regs();
        t_alarm();
        t_cd();
        t_tick();
        end_sim();
    end
    // Whole sequence needs about 53000 cycles; cut off at 100000
    initial begin
        #4000000;
        n_fail++;
        end_sim();
    end
endmodule
